// File: core/cdswc_ctrl.sv
// Purpose: Doze, sleep, idle and wake control beside a small CPU core
// Assumes: Core signals are on clk_sys; pins and reset sources are asynchronous
// Notes: Doze ratio is the log2 of peripheral instruction cycles per CPU cycle
// How it works
// R1: Doze without recovery keeps interrupt at ratio
// R2: Recovery clears doze, CPU runs full speed
// R3: Prefetched instruction runs before vector sequence
// R4: Doze on exit sets doze at return
// R5: Sleep instruction picks sleep or idle
// R6: Entering sleep clears watchdog count
// R7: Entering sleep clears power-down, sets timeout
// R8: Low and high internal oscillators keep running
// R9: Conversion survives only on dedicated oscillator
// R10: Pins hold their pre-sleep drive; the code lets lanes in gpio_async_mask follow gpio_out and gpio_oe in sleep
// R11: Non-watchdog resets stay effective asleep
// R12: Listed reset and interrupt sources wake
// R13: Reset sources reset, others continue
// R14: Sleep prefetches the next instruction
// R15: Enabled interrupt wakes regardless of global
// R16: Global enable decides vector after next
// R17: Waking clears watchdog count
// R18: Flags set regardless of any enable
// R19: Doze gives one CPU cycle per ratio
// R20: Idle stops CPU, keeps peripheral clock
`include "cdswc_regs.svh"
module cdswc_ctrl
    import cdswc_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int WDT_W = `CDSWC_WDT_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic instr_cycle,
    input wire logic doze_enable_set,
    input wire logic doze_enable_clr,
    input wire logic [`CDSWC_RATIO_W-1:0] doze_ratio,
    input wire logic recover_on_interrupt,
    input wire logic doze_on_exit,
    input wire logic idle_enable,
    input wire logic global_interrupt_enable,
    input wire logic sleep_exec,
    input wire logic [31:0] sleep_pc,
    input wire logic return_from_interrupt,
    input wire logic [NUM_IRQ-1:0] irq_cond,
    input wire logic [NUM_IRQ-1:0] irq_enable,
    input wire logic [NUM_IRQ-1:0] irq_flag_clr,
    input wire logic [NUM_IRQ-1:0] irq_runs_in_sleep,
    input wire logic ext_int_pin,
    input wire logic ext_int_enable,
    input wire logic master_clear_input,
    input wire logic master_clear_input_enable,
    input wire logic brown_out_reset,
    input wire logic bor_enable,
    input wire logic power_on_reset,
    input wire logic wdt_enable,
    input wire logic wdt_in_sleep,
    input wire logic wdt_clear,
    input wire logic [WDT_W-1:0] wdt_period,
    input wire logic adc_busy,
    input wire logic adc_on_rc_osc,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] gpio_async_mask,
    output logic doze_enable_bit,
    output logic cpu_run,
    output logic periph_clk_en,
    output logic sysclk_en,
    output logic lfo_en,
    output logic hfo_en,
    output logic [1:0] power_mode,
    output logic power_down_flag,
    output logic timeout_flag,
    output logic [WDT_W-1:0] wdt_count,
    output logic device_reset,
    output logic wake_continue,
    output logic [31:0] prefetch_pc,
    output logic prefetch_exec,
    output logic vector_req,
    output logic conversion_abort,
    output logic [NUM_IRQ-1:0] irq_flag,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    // Two-stage synchronisers for asynchronous pins and resets
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {ext_int_pin, master_clear_input, brown_out_reset, power_on_reset};
            sync2_q <= sync1_q;
        end
    end
    logic ext_s, master_clear_input_s, bor_s, por_s;
    assign ext_s = sync2_q[3];
    assign master_clear_input_s = sync2_q[2];
    assign bor_s = sync2_q[1];
    assign por_s = sync2_q[0];

    cdswc_mode_type mode_q;
    logic ext_prev_q;
    logic wdt_expire;
    logic rst_wake;
    logic int_wake;
    logic any_int_pend;
    logic asleep;

    // Reset sources act in every mode; watchdog is not one of them
    assign rst_wake = (master_clear_input_s && master_clear_input_enable) || (bor_s && bor_enable) || por_s; // [R11] [R13]
    // Enabled interrupts wake without regard to the global enable
    assign any_int_pend = |(irq_flag & irq_enable) || (ext_s && !ext_prev_q && ext_int_enable);
    assign asleep = (mode_q == CDSWC_SLEEP) || (mode_q == CDSWC_IDLE);
    assign int_wake = (mode_q == CDSWC_IDLE) ? any_int_pend
        : (|(irq_flag & irq_enable & irq_runs_in_sleep)
        || (ext_s && !ext_prev_q && ext_int_enable)); // [R12] [R15] [R20]
    assign wdt_expire = wdt_enable && (wdt_count >= wdt_period) && (wdt_period != '0);

    // External interrupt edge detection
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= ext_s;
    end

    // Flags: set wins over clear, independent of enables
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            irq_flag <= '0;
        else
            irq_flag <= (irq_flag & ~irq_flag_clr) | irq_cond; // [R18]
    end

    // Power mode sequence
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            mode_q <= CDSWC_RUN;
        else
        begin
            case (mode_q)
                CDSWC_RUN:
                    if (sleep_exec)
                        mode_q <= idle_enable ? CDSWC_IDLE : CDSWC_SLEEP; // [R5]
                CDSWC_SLEEP, CDSWC_IDLE:
                    if (rst_wake)
                        mode_q <= CDSWC_RUN;
                    else if (int_wake || wdt_expire)
                        mode_q <= CDSWC_WAKE;
                CDSWC_WAKE:
                    mode_q <= CDSWC_RUN;
                default:
                    mode_q <= CDSWC_RUN;
            endcase
        end
    end

    // Wake outcome pulses: reset or continue
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            device_reset <= 1'b0;
            wake_continue <= 1'b0;
        end
        else
        begin
            device_reset <= rst_wake; // [R13]
            wake_continue <= asleep && !rst_wake && (int_wake || wdt_expire); // [R13]
        end
    end

    // Prefetch of the instruction after sleep, run on wake
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            prefetch_pc <= 32'h0000_0000;
            prefetch_exec <= 1'b0;
        end
        else
        begin
            if (mode_q == CDSWC_RUN && sleep_exec)
                prefetch_pc <= sleep_pc + 32'h0000_0001; // [R14]
            prefetch_exec <= (mode_q == CDSWC_WAKE); // [R14] [R16]
        end
    end

    // Vector request follows the prefetched instruction
    logic vec_pend_q;
    logic recover_pend_q;
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            vec_pend_q <= 1'b0;
            vector_req <= 1'b0;
        end
        else
        begin
            vector_req <= 1'b0;
            if (mode_q == CDSWC_WAKE)
                vec_pend_q <= global_interrupt_enable && any_int_pend; // [R16]
            else if (mode_q == CDSWC_RUN && !doze_enable_bit && recover_pend_q)
                vec_pend_q <= 1'b1;
            else if (vec_pend_q && instr_cycle && cpu_run)
            begin
                vec_pend_q <= 1'b0;
                vector_req <= 1'b1; // [R3] [R16]
            end
        end
    end

    // Doze bit: recovery on interrupt clears, return with exit option sets
    logic doze_int;
    assign doze_int = doze_enable_bit && global_interrupt_enable && any_int_pend
        && mode_q == CDSWC_RUN;
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            doze_enable_bit <= `CDSWC_DOZE_RST;
            recover_pend_q <= 1'b0;
        end
        else
        begin
            recover_pend_q <= 1'b0;
            if (doze_int && recover_on_interrupt)
            begin
                doze_enable_bit <= 1'b0; // [R2]
                recover_pend_q <= 1'b1; // [R3]
            end
            else if (return_from_interrupt && doze_on_exit)
                doze_enable_bit <= 1'b1; // [R4]
            else if (doze_enable_set)
                doze_enable_bit <= 1'b1;
            else if (doze_enable_clr)
                doze_enable_bit <= 1'b0;
        end
    end

    // Doze divider: ISR keeps the reduced rate when recovery is off
    logic [(1 << `CDSWC_RATIO_W)-1:0] doze_cnt_q;
    logic [(1 << `CDSWC_RATIO_W)-1:0] doze_div;
    assign doze_div = 8'h01 << doze_ratio; // [R1]
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            doze_cnt_q <= 8'h00;
        else if (!doze_enable_bit)
            doze_cnt_q <= 8'h00;
        else if (instr_cycle)
            doze_cnt_q <= (doze_cnt_q >= doze_div - 8'h01) ? 8'h00 : doze_cnt_q + 8'h01;
    end

    // CPU gating: one cycle per ratio in doze, none while asleep
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            cpu_run <= 1'b1;
        else if (asleep || (mode_q == CDSWC_RUN && sleep_exec))
            cpu_run <= 1'b0; // [R20]
        else if (doze_enable_bit)
            cpu_run <= (doze_cnt_q == 8'h00); // [R19] [R1]
        else
            cpu_run <= 1'b1;
    end

    // Clock enables; internal oscillators never stop for sleep
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sysclk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            lfo_en <= 1'b1;
            hfo_en <= 1'b1;
            power_mode <= 2'h0;
        end
        else
        begin
            sysclk_en <= !(mode_q == CDSWC_SLEEP); // [R20]
            periph_clk_en <= !(mode_q == CDSWC_SLEEP); // [R19] [R20]
            lfo_en <= 1'b1; // [R8]
            hfo_en <= 1'b1; // [R8]
            power_mode <= mode_q;
        end
    end

    // Status flags on sleep entry
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            power_down_flag <= `CDSWC_PD_RST;
            timeout_flag <= `CDSWC_TO_RST;
        end
        else if (mode_q == CDSWC_RUN && sleep_exec)
        begin
            power_down_flag <= 1'b0; // [R7]
            timeout_flag <= 1'b1; // [R7]
        end
        else if (asleep && wdt_expire)
            timeout_flag <= 1'b0;
    end

    // Watchdog: cleared on entry and wake, counts asleep only if allowed
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            wdt_count <= `CDSWC_WDT_RST;
        else if (mode_q == CDSWC_RUN && sleep_exec)
            wdt_count <= '0; // [R6]
        else if (mode_q == CDSWC_WAKE || (asleep && rst_wake))
            wdt_count <= '0; // [R17]
        else if (wdt_clear || (mode_q == CDSWC_RUN && wdt_expire))
            wdt_count <= '0;
        else if (wdt_enable && (!asleep || wdt_in_sleep) && !wdt_expire)
            wdt_count <= wdt_count + 1'b1; // [R6]
    end

    // Conversion abandoned only when clocked from the system clock
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            conversion_abort <= 1'b0;
        else
            conversion_abort <= (mode_q == CDSWC_SLEEP) && adc_busy && !adc_on_rc_osc; // [R9]
    end

    // Pins frozen in sleep except lanes owned by async peripherals
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end
        else if (mode_q == CDSWC_SLEEP)
        begin
            pin_out <= (pin_out & ~gpio_async_mask) | (gpio_out & gpio_async_mask); // [R10]
            pin_oe <= (pin_oe & ~gpio_async_mask) | (gpio_oe & gpio_async_mask); // [R10]
        end
        else
        begin
            pin_out <= gpio_out;
            pin_oe <= gpio_oe;
        end
    end
endmodule // cdswc_ctrl

// File: core/cdswc_regs.svh
// Purpose: Constants for the doze, sleep and wake controller
// Assumes: Included by its bare name
// Notes: Reset values of the control state
`ifndef CDSWC_REGS_SVH
`define CDSWC_REGS_SVH
`define CDSWC_RATIO_W 3
`define CDSWC_DOZE_RST 1'b0
`define CDSWC_PD_RST 1'b1
`define CDSWC_TO_RST 1'b1
`define CDSWC_WDT_W 16
`define CDSWC_WDT_RST 16'h0000
`define CDSWC_LFO_KHZ 31
`endif

// File: core/cdswc_pkg.sv
// Purpose: Types for the doze, sleep and wake controller
// Assumes: Nothing
// Notes: Power modes of the core
package cdswc_pkg;
    typedef enum logic [1:0] {
        CDSWC_RUN,
        CDSWC_SLEEP,
        CDSWC_IDLE,
        CDSWC_WAKE
    } cdswc_mode_type;
endpackage

// File: sim/cdswc_sva.sv
// Purpose: Port checks for the doze, sleep and wake controller
// Assumes: Bound to cdswc_ctrl, one clock domain
// Notes: Mode codes are 0 run, 1 sleep, 2 idle, 3 wake
module cdswc_sva #(
    parameter int NUM_IRQ = 8
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sleep_exec,
    input wire logic idle_enable,
    input wire logic [31:0] sleep_pc,
    input wire logic return_from_interrupt,
    input wire logic doze_on_exit,
    input wire logic [NUM_IRQ-1:0] irq_cond,
    input wire logic power_on_reset,
    input wire logic [1:0] power_mode,
    input wire logic power_down_flag,
    input wire logic timeout_flag,
    input wire logic [15:0] wdt_count,
    input wire logic cpu_run,
    input wire logic periph_clk_en,
    input wire logic lfo_en,
    input wire logic hfo_en,
    input wire logic [31:0] prefetch_pc,
    input wire logic prefetch_exec,
    input wire logic doze_enable_bit,
    input wire logic [NUM_IRQ-1:0] irq_flag,
    input wire logic device_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Sleep instruction accepted only in run mode
    sequence take_s;
        power_mode == 2'h0 && sleep_exec;
    endsequence
    sleep_pick_a:
        assert property (take_s |-> ##2 power_mode == ($past(idle_enable, 2) ? 2'h2 : 2'h1))
        else $error("sleep instruction chose the wrong mode");
    sleep_flags_a:
        assert property (take_s ##0 !idle_enable |=> !power_down_flag && timeout_flag && wdt_count == 16'h0000)
        else $error("sleep entry flags or watchdog wrong");
    next_pc_a:
        assert property (take_s |=> prefetch_pc == $past(sleep_pc) + 32'h0000_0001)
        else $error("prefetch address is not the next one");
    asleep_osc_a:
        assert property (power_mode == 2'h1 |-> !cpu_run && lfo_en && hfo_en)
        else $error("sleep stopped an oscillator or left the cpu running");
    idle_clock_a:
        assert property (power_mode == 2'h2 |-> !cpu_run && periph_clk_en)
        else $error("idle mode clocks wrong");
    wake_step_a:
        assert property (power_mode == 2'h3 |-> prefetch_exec ##1 power_mode == 2'h0)
        else $error("wake did not run the prefetched instruction");
    wake_wdt_a:
        assert property (power_mode == 2'h3 |-> wdt_count == 16'h0000)
        else $error("watchdog count not cleared on wake");
    flag_set_a:
        assert property (irq_cond[0] |=> irq_flag[0])
        else $error("interrupt flag not set by its condition");
    doze_exit_a:
        assert property (return_from_interrupt && doze_on_exit |=> doze_enable_bit)
        else $error("return did not re-enter doze");
    por_reset_a:
        assert property ($rose(power_on_reset) |-> ##[1:4] device_reset)
        else $error("power-on reset did not reset the device");
endmodule // cdswc_sva

// File: sim/cdswc_cpu_model.sv
// Purpose: CPU core facing the power controller
// Assumes: Changes its outputs on the falling edge
// Notes: One instruction cycle every fourth clock
module cdswc_cpu_model
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cpu_run,
    output logic instr_cycle,
    output logic [31:0] sleep_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q = 2'h0;
    logic [31:0] pc_q = 32'h0000_0100;
    // Program counter moves only while the controller lets the cpu run
    always @(negedge clk_sys)
    begin
        phase_q <= reset_n ? phase_q + 2'h1 : 2'h0;
        if (!reset_n)
            pc_q <= 32'h0000_0100;
        else if (instr_cycle && cpu_run)
            pc_q <= pc_q + 32'h0000_0001;
    end
    assign instr_cycle = (phase_q == 2'h3);
    assign sleep_pc = pc_q;
endmodule // cdswc_cpu_model

// File: sim/tb.sv
// Purpose: Self-checking bench for the doze, sleep and wake controller
// Assumes: Inputs change on the falling edge
// Notes: Watchdog runs only in its own scenario so other wakes stay predictable
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cdswc_pkg::*;
    logic clk_sys, reset_n, instr_cycle, doze_enable_set, doze_enable_clr;
    logic recover_on_interrupt, doze_on_exit, idle_enable, global_interrupt_enable;
    logic sleep_exec, return_from_interrupt, ext_int_pin, ext_int_enable;
    logic master_clear_input, master_clear_input_enable, brown_out_reset, bor_enable, power_on_reset;
    logic wdt_enable, wdt_in_sleep, wdt_clear, adc_busy, adc_on_rc_osc;
    logic [2:0] doze_ratio;
    logic [31:0] sleep_pc, prefetch_pc, pc_e;
    logic [7:0] irq_cond, irq_enable, irq_flag_clr, irq_runs_in_sleep, irq_flag;
    logic [7:0] gpio_out, gpio_oe, gpio_async_mask, pin_out, pin_oe;
    logic [15:0] wdt_period, wdt_count;
    logic doze_enable_bit, cpu_run, periph_clk_en, sysclk_en, lfo_en, hfo_en;
    logic power_down_flag, timeout_flag, device_reset, wake_continue;
    logic prefetch_exec, vector_req, conversion_abort;
    logic [1:0] power_mode;
    int mismatches = 0;
    int cmp_count = 0;
    cdswc_ctrl dut_u (.*);
    cdswc_cpu_model cpu_u (.*);
    // Shared compare, four-state so unknowns fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int n = 0; n < 40 && power_mode !== m; n++) @(negedge clk_sys);
        chk(power_mode, m);
    endtask
    task automatic pulse_irq(input int i);
        @(negedge clk_sys);
        irq_cond[i] = 1'b1;
        @(negedge clk_sys);
        irq_cond[i] = 1'b0;
    endtask
    task automatic clr_flags();
        @(negedge clk_sys);
        irq_flag_clr = 8'hFF;
        @(negedge clk_sys);
        irq_flag_clr = 8'h00;
    endtask
    // Sleep instruction; address captured where the core samples it
    task automatic do_sleep(input logic idle);
        @(negedge clk_sys);
        idle_enable = idle;
        sleep_exec = 1'b1;
        @(posedge clk_sys);
        pc_e = sleep_pc + 32'h0000_0001;
        @(negedge clk_sys);
        sleep_exec = 1'b0;
        // Mode output trails the internal state by one clock
        @(negedge clk_sys);
        chk(power_mode, idle ? 2'h2 : 2'h1);
        chk(prefetch_pc, pc_e);
    endtask
    task automatic t_sleep();
        global_interrupt_enable = 1'b1;
        irq_enable = 8'h01;
        irq_runs_in_sleep = 8'h01;
        adc_busy = 1'b1;
        do_sleep(1'b0);
        chk({power_down_flag, timeout_flag, lfo_en, hfo_en, cpu_run}, 5'h0E);
        chk(wdt_count, 16'h0000);
        gpio_out = 8'h5A;
        @(negedge clk_sys);
        chk({conversion_abort, sysclk_en, pin_out}, {1'b1, 1'b0, 8'hA5});
        pulse_irq(0);
        chk(irq_flag[0], 1'b1);
        @(negedge clk_sys);
        chk(wake_continue, 1'b1);
        wait_mode(2'h0);
        for (int n = 0; n < 40 && vector_req !== 1'b1; n++) @(negedge clk_sys);
        chk(vector_req, 1'b1);
        clr_flags();
    endtask
    // Idle wakes on an enabled source with the global enable off
    task automatic t_idle();
        global_interrupt_enable = 1'b0;
        irq_enable = 8'h02;
        irq_runs_in_sleep = 8'h00;
        do_sleep(1'b1);
        chk({periph_clk_en, cpu_run}, 2'h2);
        pulse_irq(1);
        wait_mode(2'h0);
        // Global enable off: no vector after the wake
        for (int n = 0; n < 8; n++)
        begin
            @(negedge clk_sys);
            chk(vector_req, 1'b0);
        end
        clr_flags();
        idle_enable = 1'b0;
    endtask
    task automatic t_flag();
        irq_enable = 8'h00;
        pulse_irq(2);
        chk(irq_flag[2], 1'b1);
        clr_flags();
        chk(irq_flag, 8'h00);
    endtask
    task automatic t_doze();
        doze_on_exit = 1'b1;
        @(negedge clk_sys);
        return_from_interrupt = 1'b1;
        @(negedge clk_sys);
        return_from_interrupt = 1'b0;
        chk(doze_enable_bit, 1'b1);
        // Ratio value 2 lets one cpu cycle through per four instruction cycles
        pc_e = sleep_pc;
        repeat (64) @(negedge clk_sys);
        chk(sleep_pc - pc_e, 32'h0000_0004);
        global_interrupt_enable = 1'b1;
        irq_enable = 8'h01;
        pulse_irq(0);
        repeat (4) @(negedge clk_sys);
        chk(doze_enable_bit, 1'b1);
        clr_flags();
        recover_on_interrupt = 1'b1;
        pulse_irq(0);
        for (int n = 0; n < 40 && doze_enable_bit !== 1'b0; n++) @(negedge clk_sys);
        chk(doze_enable_bit, 1'b0);
        clr_flags();
    endtask
    // Reset source while asleep gives a full reset, not a wake
    task automatic t_por();
        irq_enable = 8'h00;
        adc_on_rc_osc = 1'b1;
        do_sleep(1'b0);
        chk(conversion_abort, 1'b0);
        power_on_reset = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({device_reset, wake_continue}, 2'h2);
        power_on_reset = 1'b0;
        wait_mode(2'h0);
    endtask
    // Watchdog wake clears the count; a later entry sets timeout again
    task automatic t_wdt();
        {wdt_enable, wdt_in_sleep} = 2'h3;
        wdt_period = 16'h0010;
        do_sleep(1'b0);
        wait_mode(2'h3);
        chk({wdt_count, timeout_flag}, 17'h0_0000);
        wdt_enable = 1'b0;
        irq_enable = 8'h01;
        do_sleep(1'b1);
        chk(timeout_flag, 1'b1);
        pulse_irq(0);
        wait_mode(2'h0);
        clr_flags();
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Hang guard, far beyond the few hundred cycles used
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        reset_n = 1'b0;
        {doze_enable_set, doze_enable_clr, recover_on_interrupt, doze_on_exit} = 4'h0;
        {idle_enable, global_interrupt_enable, sleep_exec, return_from_interrupt} = 4'h0;
        {ext_int_pin, ext_int_enable, master_clear_input, master_clear_input_enable} = 4'h0;
        {brown_out_reset, bor_enable, power_on_reset, wdt_enable, wdt_in_sleep} = 5'h00;
        {wdt_clear, adc_busy, adc_on_rc_osc} = 3'h0;
        {irq_cond, irq_enable, irq_flag_clr, irq_runs_in_sleep} = 32'h0000_0000;
        {gpio_out, gpio_oe, gpio_async_mask} = 24'hA5_FF00;
        doze_ratio = 3'h2;
        wdt_period = 16'h0000;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        t_sleep();
        t_idle();
        t_flag();
        t_doze();
        t_por();
        t_wdt();
        complete_run();
    end
endmodule // tb
bind cdswc_ctrl cdswc_sva #(.NUM_IRQ(NUM_IRQ)) sva_u (.*);
